// ---- hw/ocfr_top.sv ----
`timescale 1ns/100ps
`include "ocfr_regs.svh"
// over-current fault reaction: threshold, reaction setting, retry sequencing
module ocfr_top (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire ocfr_pkg::ocfr_cmd_s cmd,
  output ocfr_pkg::ocfr_rsp_s     rsp,
  input  wire ocfr_pkg::ocfr_ctl_s ctl,
  input  wire logic [15:0]        iout_measured,
  input  wire logic [15:0]        time_unit_cycles,
  output logic                    output_enable,
  output logic                    oc_fault_status,
  output logic                    retrying,
  output logic [2:0]              attempts_left
);

  logic [7:0]            reaction_q;
  logic [15:0]           threshold_q;
  ocfr_pkg::ocfr_rsp_s   rsp_q;
  ocfr_pkg::ocfr_state_e state_q;
  ocfr_pkg::ocfr_state_e state_d;
  logic [2:0]            left_q;
  logic [2:0]            left_d;
  logic                  on_q;
  logic                  status_q;
  logic                  enable_q;
  logic                  timer_start;
  logic                  timer_done;
  logic                  oc_now;
  logic                  on_cmd;
  logic                  off_edge;
  logic                  cleared;
  logic                  fault_hit;
  logic                  wr_hit;
  logic [1:0]            react;
  logic [2:0]            retry_set;
  logic                  forever_mode;

  assign react        = reaction_q[`OCFR_REACT_MSB:`OCFR_REACT_LSB];
  assign retry_set    = reaction_q[`OCFR_RETRY_MSB:`OCFR_RETRY_LSB];
  assign forever_mode = retry_set == `OCFR_RETRY_FOREVER;
  assign on_cmd       = ctl.ctrl_pin_on && ctl.operation_on;
  assign off_edge     = on_q && !on_cmd;
  assign cleared      = ctl.clear_faults || ctl.status_clear || off_edge;
  assign wr_hit       = cmd.valid && cmd.write;

  ocfr_lin_cmp u_cmp (
    .clk      (clk),
    .rst      (rst),
    .measured (iout_measured),
    .limit    (threshold_q),
    .exceed   (oc_now)
  );

  ocfr_delay_timer u_timer (
    .clk         (clk),
    .rst         (rst),
    .start       (timer_start),
    .unit_cycles (time_unit_cycles),
    .exponent    (reaction_q[`OCFR_DELAY_MSB:`OCFR_DELAY_LSB]),
    .done        (timer_done)
  );

  // register writes by command code
  always_ff @(posedge clk)
  begin
    if (rst)
      reaction_q <= `OCFR_REACTION_RST;
    else if (wr_hit && cmd.code == `OCFR_CODE_REACTION)
      reaction_q <= cmd.wdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      threshold_q <= `OCFR_THRESHOLD_RST;
    else if (wr_hit && cmd.code == `OCFR_CODE_THRESHOLD)
      threshold_q <= cmd.wdata;
  end

  // reads answer one cycle later; unknown codes read zero and flag it
  always_ff @(posedge clk)
  begin
    if (rst)
      rsp_q <= '0;
    else
    begin
      rsp_q.rd_valid <= cmd.valid && !cmd.write;
      rsp_q.unmapped <= 1'b0;
      rsp_q.rd_data  <= 16'h0000;
      if (cmd.valid && !cmd.write)
      begin
        if (cmd.code == `OCFR_CODE_REACTION)
          rsp_q.rd_data <= {8'h00, reaction_q};
        else if (cmd.code == `OCFR_CODE_THRESHOLD)
          rsp_q.rd_data <= threshold_q;
        else
          rsp_q.unmapped <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      on_q <= 1'b0;
    else
      on_q <= on_cmd;
  end

  // only a live output with a non-ignore reaction can see a fault
  assign fault_hit = oc_now && on_cmd && react != ocfr_pkg::OCFR_IGNORE;

  // sequencing of reactions and retries
  always_comb
  begin
    state_d     = state_q;
    left_d      = left_q;
    timer_start = 1'b0;
    if (ctl.other_shutdown)
      state_d = ocfr_pkg::OCFR_ST_LATCH;
    else if (cleared)
    begin
      state_d = ocfr_pkg::OCFR_ST_RUN;
      left_d  = 3'h0;
    end
    else
    begin
      unique case (state_q)
        ocfr_pkg::OCFR_ST_RUN:
        begin
          if (fault_hit)
          begin
            unique case (react)
              ocfr_pkg::OCFR_DEGLITCH:
              begin
                state_d     = ocfr_pkg::OCFR_ST_DEGLITCH;
                timer_start = 1'b1;
              end
              ocfr_pkg::OCFR_SHUTDOWN:
              begin
                left_d = retry_set;
                if (retry_set == `OCFR_RETRY_NONE)
                  state_d = ocfr_pkg::OCFR_ST_LATCH;
                else
                begin
                  state_d     = ocfr_pkg::OCFR_ST_SPACE;
                  timer_start = 1'b1;
                end
              end
              ocfr_pkg::OCFR_HOLD_OFF:
                state_d = ocfr_pkg::OCFR_ST_HOLD;
              default:
                state_d = ocfr_pkg::OCFR_ST_RUN;
            endcase
          end
        end
        ocfr_pkg::OCFR_ST_DEGLITCH:
        begin
          // fault gone before the delay ran out: carry on untouched
          if (!oc_now)
            state_d = ocfr_pkg::OCFR_ST_RUN;
          else if (timer_done)
          begin
            left_d = retry_set;
            if (retry_set == `OCFR_RETRY_NONE)
              state_d = ocfr_pkg::OCFR_ST_LATCH;
            else
            begin
              state_d     = ocfr_pkg::OCFR_ST_SPACE;
              timer_start = 1'b1;
            end
          end
        end
        ocfr_pkg::OCFR_ST_SPACE:
        begin
          if (timer_done)
          begin
            state_d     = ocfr_pkg::OCFR_ST_PROBE;
            timer_start = 1'b1;
            if (!forever_mode)
              left_d = left_q - 3'h1;
          end
        end
        ocfr_pkg::OCFR_ST_PROBE:
        begin
          // timer keeps running, so attempt starts stay one delay apart
          if (oc_now)
          begin
            if (forever_mode || left_q != 3'h0)
              state_d = ocfr_pkg::OCFR_ST_SPACE;
            else
              state_d = ocfr_pkg::OCFR_ST_LATCH;
          end
          else if (timer_done)
          begin
            state_d = ocfr_pkg::OCFR_ST_RUN;
            left_d  = 3'h0;
          end
        end
        ocfr_pkg::OCFR_ST_LATCH:
          state_d = ocfr_pkg::OCFR_ST_LATCH;
        ocfr_pkg::OCFR_ST_HOLD:
        begin
          if (!oc_now)
            state_d = ocfr_pkg::OCFR_ST_RUN;
        end
        default:
          state_d = ocfr_pkg::OCFR_ST_LATCH;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ocfr_pkg::OCFR_ST_RUN;
      left_q  <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      left_q  <= left_d;
    end
  end

  // sticky status; a new fault in the clear cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (rst)
      status_q <= 1'b0;
    else if (fault_hit && state_q == ocfr_pkg::OCFR_ST_RUN)
      status_q <= 1'b1;
    else if (cleared)
      status_q <= 1'b0;
  end

  // output is on only in states that keep the converter running
  always_ff @(posedge clk)
  begin
    if (rst)
      enable_q <= 1'b0;
    else
      enable_q <= on_cmd && (state_d == ocfr_pkg::OCFR_ST_RUN
                          || state_d == ocfr_pkg::OCFR_ST_DEGLITCH
                          || state_d == ocfr_pkg::OCFR_ST_PROBE);
  end

  assign rsp             = rsp_q;
  assign output_enable   = enable_q;
  assign oc_fault_status = status_q;
  assign retrying        = state_q == ocfr_pkg::OCFR_ST_SPACE
                        || state_q == ocfr_pkg::OCFR_ST_PROBE;
  assign attempts_left   = left_q;

endmodule

// ---- hw/ocfr_regs.svh ----
`ifndef OCFR_REGS_SVH
`define OCFR_REGS_SVH
// Overview of operation
// - hold a 16-bit linear amperes trip threshold and compare with measured current
// - reaction taken from bits 7:6; code 00 ignores the fault and keeps running
// - code 01 keeps running for the delay, then shuts down and follows the retry setting if fault still present
// - code 10 disables output immediately, then follows the retry count in bits 5:3
// - code 11 keeps output off only while fault lasts, then re-enables automatically
// - latched fault clears by status clear, clear-faults, reset, or off-then-on command
// - retry field 000 makes no restart; output stays off until cleared
// - retry codes 001-011 give 1-3 attempts spaced by delay; then off until cleared
// - retry field 111 keeps restarting without limit
// - retry codes 100-110 give 4-6 attempts, same spacing and final behaviour
// - bits 2:0 give 2^n time units of delay; unit set elsewhere
// - continuous retry stops only on off command or another shutdown fault; here a probe that ends with the fault gone also ends it

// command codes of the two registers, plus a time-unit code that has no register here
`define OCFR_CODE_REACTION   8'h41
`define OCFR_CODE_THRESHOLD  8'h46
`define OCFR_CODE_TIME_UNIT  8'hd2

// fields of the reaction setting
`define OCFR_REACT_MSB       7
`define OCFR_REACT_LSB       6
`define OCFR_RETRY_MSB       5
`define OCFR_RETRY_LSB       3
`define OCFR_DELAY_MSB       2
`define OCFR_DELAY_LSB       0

// retry field encodings
`define OCFR_RETRY_NONE      3'h0
`define OCFR_RETRY_FOREVER   3'h7

// reset values
`define OCFR_REACTION_RST    8'h00
`define OCFR_THRESHOLD_RST   16'h0000
`endif

// ---- hw/ocfr_pkg.sv ----
package ocfr_pkg;

  typedef enum logic [1:0] {
    OCFR_IGNORE   = 2'b00,
    OCFR_DEGLITCH = 2'b01,
    OCFR_SHUTDOWN = 2'b10,
    OCFR_HOLD_OFF = 2'b11
  } ocfr_react_e;

  typedef enum logic [2:0] {
    OCFR_ST_RUN      = 3'b000,
    OCFR_ST_DEGLITCH = 3'b001,
    OCFR_ST_SPACE    = 3'b010,
    OCFR_ST_PROBE    = 3'b011,
    OCFR_ST_LATCH    = 3'b100,
    OCFR_ST_HOLD     = 3'b101
  } ocfr_state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } ocfr_cmd_s;

  typedef struct packed {
    logic        rd_valid;
    logic        unmapped;
    logic [15:0] rd_data;
  } ocfr_rsp_s;

  typedef struct packed {
    logic ctrl_pin_on;
    logic operation_on;
    logic clear_faults;
    logic status_clear;
    logic other_shutdown;
  } ocfr_ctl_s;

endpackage

// ---- hw/ocfr_lin_cmp.sv ----
`timescale 1ns/100ps
// linear-format magnitude compare, one cycle of latency
module ocfr_lin_cmp (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] measured,
  input  wire logic [15:0] limit,
  output logic             exceed
);

  logic exceed_q;

  // 5-bit signed exponent, 11-bit signed mantissa; shift to a common fixed point
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
    logic [5:0]         sh;
    logic signed [47:0] x;
    sh = {v[15], v[15:11]} + 6'h10;
    x  = {{37{v[10]}}, v[10:0]};
    return x <<< sh;
  endfunction

  always_ff @(posedge clk)
  begin
    if (rst)
      exceed_q <= 1'b0;
    else
      exceed_q <= lin_to_fix(measured) > lin_to_fix(limit);
  end

  assign exceed = exceed_q;

endmodule

// ---- hw/ocfr_delay_timer.sv ----
`timescale 1ns/100ps
// counts 2^n time units; done pulses once, one cycle before the count runs out
module ocfr_delay_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] unit_cycles,
  input  wire logic [2:0]  exponent,
  output logic             done
);

  logic [22:0] count_q;
  logic        done_q;
  logic [22:0] load;

  // a zero unit would never expire, so it counts as one cycle
  always_comb
  begin
    load = {7'h00, (unit_cycles == 16'h0000) ? 16'h0001 : unit_cycles} << exponent;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      count_q <= 23'h000000;
    else if (start)
      count_q <= load;
    else if (count_q != 23'h000000)
      count_q <= count_q - 23'h000001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      done_q <= 1'b0;
    else
      // flagged one cycle early so the next start lands exactly one delay later
      done_q <= start ? (load == 23'h000001) : (count_q == 23'h000002);
  end

  assign done = done_q;

endmodule

// ---- sim/ocfr_monitor.sv ----
`timescale 1ns/100ps
module ocfr_monitor (
  input wire logic                clk,
  input wire logic                rst,
  input wire ocfr_pkg::ocfr_cmd_s cmd,
  input wire ocfr_pkg::ocfr_rsp_s rsp,
  input wire ocfr_pkg::ocfr_ctl_s ctl,
  input wire logic [15:0]         iout_measured,
  input wire logic [15:0]         time_unit_cycles,
  input wire logic                output_enable,
  input wire logic                oc_fault_status,
  input wire logic                retrying,
  input wire logic [2:0]          attempts_left
);
  // shadow of the reaction setting, rebuilt from writes
  logic [7:0] cfg_q;
  logic       on;
  assign on = ctl.ctrl_pin_on && ctl.operation_on;
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= 8'h00;
    else if (cmd.valid && cmd.write && cmd.code == 8'h41)
      cfg_q <= cmd.wdata[7:0];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_rd;
    cmd.valid && !cmd.write;
  endsequence
  sequence s_off2;
    !on ##1 !on;
  endsequence
  property p_reset;
    disable iff (1'b0) rst |=> !output_enable && !oc_fault_status && !rsp.rd_valid;
  endproperty
  property p_read;
    s_rd |=> rsp.rd_valid;
  endproperty
  property p_unmapped;
    s_rd ##0 (cmd.code != 8'h41 && cmd.code != 8'h46) |=> rsp.unmapped && rsp.rd_data == 16'h0000;
  endproperty
  // one cycle of history so a setting written mid-decision is not blamed
  property p_ignore;
    cfg_q[7:6] == 2'b00 && $past(cfg_q[7:6]) == 2'b00 |-> !$rose(oc_fault_status);
  endproperty
  property p_clear;
    cfg_q[7:6] == 2'b00 && $past(cfg_q[7:6]) == 2'b00 && ctl.clear_faults |=> !oc_fault_status;
  endproperty
  property p_sticky;
    oc_fault_status && on && !ctl.clear_faults && !ctl.status_clear |=> oc_fault_status;
  endproperty
  property p_off;
    s_off2 |-> !output_enable;
  endproperty
  property p_retry;
    retrying && cfg_q[5:3] != 3'h7 |-> attempts_left <= cfg_q[5:3];
  endproperty
  a_reset: assert property (p_reset) else $error("reset left outputs set");
  a_read: assert property (p_read) else $error("read not answered");
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped answer");
  a_ignore: assert property (p_ignore) else $error("status set while ignoring");
  a_clear: assert property (p_clear) else $error("clear did not clear");
  a_sticky: assert property (p_sticky) else $error("status dropped");
  a_off: assert property (p_off) else $error("output on while off");
  a_retry: assert property (p_retry) else $error("attempts above setting");
endmodule
bind ocfr_top ocfr_monitor u_mon (.clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp), .ctl(ctl),
  .iout_measured(iout_measured), .time_unit_cycles(time_unit_cycles),
  .output_enable(output_enable), .oc_fault_status(oc_fault_status),
  .retrying(retrying), .attempts_left(attempts_left));

// ---- sim/ocfr_host.sv ----
`timescale 1ns/100ps
// host side of the command port; one command per call
module ocfr_host (
  input  wire logic                clk,
  output ocfr_pkg::ocfr_cmd_s      cmd,
  input  wire ocfr_pkg::ocfr_rsp_s rsp
);
  initial cmd = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output ocfr_pkg::ocfr_rsp_s r);
    @(posedge clk);
    #1 cmd = '{1'b1, w, c, d};
    @(posedge clk);
    #1 r = rsp;
    // idle fields scrambled so a stale code is never mistaken for valid
    cmd = '{1'b0, 1'b0, ~c, ~d};
  endtask
endmodule

// ---- sim/tb_ocfr_top.sv ----
`timescale 1ns/100ps
module tb_ocfr_top;
  logic                clk;
  logic                rst;
  ocfr_pkg::ocfr_cmd_s cmd;
  ocfr_pkg::ocfr_rsp_s rsp;
  ocfr_pkg::ocfr_rsp_s r;
  ocfr_pkg::ocfr_ctl_s ctl;
  logic [15:0]         iout;
  logic [15:0]         unit;
  logic [15:0]         thr;
  logic                oe;
  logic                st;
  logic                rtg;
  logic [2:0]          al;
  logic [31:0]         seed;
  int                  failures;
  int                  n_compared;
  int                  cyc;
  ocfr_top DUT (.clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp), .ctl(ctl), .iout_measured(iout),
    .time_unit_cycles(unit), .output_enable(oe), .oc_fault_status(st), .retrying(rtg),
    .attempts_left(al));
  ocfr_host host (.clk(clk), .cmd(cmd), .rsp(rsp));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int dly(input logic [2:0] n);
    return int'(unit) << n;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.xfer(1'b1, c, d, r);
  endtask
  task automatic rd(input logic [7:0] c);
    host.xfer(1'b0, c, 16'h0000, r);
  endtask
  task automatic clr(input int m);
    case (m)
      0: ctl.clear_faults = 1'b1;
      1: ctl.status_clear = 1'b1;
      2: ctl.operation_on = 1'b0;
      default: rst = 1'b1;
    endcase
    tick(1);
    ctl = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    rst = 1'b0;
    tick(3);
    chk({14'h0, st, oe}, 16'h0001, "cleared");
  endtask
  task automatic run_retry(input logic [2:0] k, input logic [2:0] n, input int m);
    int   cnt;
    int   last;
    int   i;
    logic p;
    cnt = 0;
    last = 0;
    p = 1'b1;
    wr(8'h46, thr);
    wr(8'h41, {8'h00, 2'b10, k, n});
    iout = thr + 16'h0001;
    for (i = 0; i < 3000 && !(st === 1'b1 && rtg === 1'b0); i++)
    begin
      tick(1);
      if (i == 1)
        chk(16'(oe), 16'h0000, "shutdown");
      if (oe === 1'b1 && p !== 1'b1)
      begin
        if (cnt > 0)
          chk(16'(i - last), 16'(dly(n)), "spacing");
        cnt++;
        last = i;
      end
      p = oe;
      if (k == 3'h7 && i == 40 * dly(n))
        break;
    end
    if (k == 3'h7)
    begin
      chk(16'(cnt > 8 && rtg === 1'b1), 16'h0001, "endless");
      ctl.operation_on = 1'b0;
      tick(4);
      chk({14'h0, rtg, oe}, 16'h0000, "stopped");
    end
    else
    begin
      chk(16'(cnt), 16'(k), "attempts");
      tick(3 * dly(n));
      chk({14'h0, st, oe}, 16'h0002, "stays off");
    end
    iout = thr;
    clr(m);
    $display("retry code %0d done", k);
  endtask
  initial
  begin
    failures = 0;
    n_compared = 0;
    cyc = 0;
    seed = 32'h9584a3a7;
    rst = 1'b1;
    ctl = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    iout = 16'h0000;
    unit = 16'h0002;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h41);
    chk(r.rd_data, 16'h0000, "cfg reset");
    rd(8'h46);
    chk(r.rd_data, 16'h0000, "thr reset");
    seed = lfsr(seed);
    // exponent kept at zero so thr + 1 stays a plain larger number
    thr = {7'h00, seed[8:0]};
    wr(8'h46, thr);
    rd(8'h46);
    chk(r.rd_data, thr, "thr rw");
    wr(8'h41, 16'hffaa);
    wr(8'h50, 16'h1234);
    rd(8'h41);
    chk(r.rd_data, 16'h00aa, "cfg rw");
    rd(8'h50);
    chk(r.rd_data | {r.rd_valid, r.unmapped, 14'h0}, 16'hc000, "unmapped");
    $display("registers done");
    wr(8'h41, 16'h0000);
    iout = thr + 16'h0001;
    tick(10);
    chk({14'h0, st, oe}, 16'h0001, "ignored");
    clr(0);
    iout = thr;
    wr(8'h41, 16'h0080);
    tick(10);
    chk({14'h0, st, oe}, 16'h0001, "equal limit");
    ctl.other_shutdown = 1'b1;
    tick(3);
    chk(16'(oe), 16'h0000, "other shutdown");
    ctl.other_shutdown = 1'b0;
    tick(1);
    clr(0);
    wr(8'h41, 16'h00c0);
    iout = thr + 16'h0001;
    tick(4);
    chk(16'(oe), 16'h0000, "held off");
    iout = thr;
    tick(4);
    chk(16'(oe), 16'h0001, "resumed");
    clr(0);
    wr(8'h41, {8'h00, 5'b01000, seed[12:10]});
    iout = thr + 16'h0001;
    tick(dly(seed[12:10]));
    chk(16'(oe), 16'h0001, "deglitch run");
    tick(8);
    chk({14'h0, st, oe}, 16'h0002, "deglitch off");
    iout = thr;
    clr(1);
    $display("reactions done");
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      run_retry(3'(k), {1'b0, seed[1:0]}, k % 4);
    end
    seed = lfsr(seed);
    run_retry(seed[2:0], 3'h0, 2);
    summarize();
  end
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
endmodule
